// ### hw/ipa_pkg.sv
package ipa_pkg;
    // -----------------------------------------
    // Geometry
    // -----------------------------------------
    localparam int NUM_LEVELS = 8;
    localparam int LEVEL_W = 3;
    localparam logic [2:0] LEVEL_LOWEST = 3'h7;
    localparam int ADDR_W = 12;

    // -----------------------------------------
    // Register map (byte addresses)
    // -----------------------------------------
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_SRC_BASE = 12'h040;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // -----------------------------------------
    // Request control word fields
    // -----------------------------------------
    localparam int FLD_PEND = 7;
    localparam int FLD_MASK = 6;
    localparam int FLD_PRIO_LSB = 0;
    localparam logic RST_MASK = 1'b1;

    // -----------------------------------------
    // Status word fields
    // -----------------------------------------
    localparam int STAT_ISR_LSB = 0;
    localparam int STAT_GATE = 8;
    localparam int STAT_NMI = 9;
    localparam int STAT_BUSY = 10;
    localparam logic GATE_RESET = 1'b1;

    // -----------------------------------------
    // Timing in system clocks
    // -----------------------------------------
    localparam int ACK_WINDOW_CLKS = 7;
    localparam int ACK_PROC_CLKS = 4;
    localparam int NOISE_CLKS = 2;
    localparam logic [2:0] WIN_LAST = 3'(ACK_WINDOW_CLKS - 1);
    localparam logic [2:0] PROC_LAST = 3'(ACK_PROC_CLKS - 1);
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [7:0] ISR_ONE = 8'h01;

    // -----------------------------------------
    // Types
    // -----------------------------------------
    typedef enum logic [1:0] {
        KIND_NMI,
        KIND_MASKABLE,
        KIND_TRAP,
        KIND_ILLEGAL
    } ipa_kind_t;

    typedef enum logic {
        ST_IDLE,
        ST_PROC
    } ipa_state_t;
endpackage

// ### hw/ipa_irq_ctrl.sv
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
// Functional notes
// - Reset overrides everything; no request is taken while reset is high.
// - Fixed order: non-maskable, maskable, software trap, illegal opcode.
// - Higher-priority maskable request preempts the routine in service.
// - Equal or lower priority than in-service level stays pending.
// - Maskable nesting only while the gate flag is clear.
// - Each maskable source has a 3-bit level, 0 highest, 7 lowest.
// - Reset masks every source and sets its level to 7.
// - Preempted routine resumes only after the higher one returns.
// - Pending request taken only after current routine returns.
// - No maskable acknowledge while non-maskable handler is active.
// - Least latency 11 clocks internal, 13 external.
// - Most latency 18 internal, 20 external, waived in stated cases.
// - External pins pass a noise filter adding two clocks.
// - Handler starts four clocks after acknowledge; here handlerStart rises three clocks after ackPulse.
// - No acknowledge right after allow, block or status-word load ops.
// - Pending unmasked request taken seven clocks after allow op.
// - Block op within those seven clocks cancels the acknowledge.
// - Gate set within seven clocks of pending rise cancels acknowledge.
// - Window void in low power, non-sampling op or control access.
// - Maskable acknowledge sets the gate flag.
// - In-service bit set on maskable acknowledge, cleared on maskable return.
module ipa_irq_ctrl #(
    parameter int NUM_INT = 4,
    parameter int NUM_EXT = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [NUM_INT-1:0] intReq,
    input wire logic [NUM_EXT-1:0] externalIntPin,
    input wire logic nmiReq,
    input wire logic trapReq,
    input wire logic illegalOpcodeException,
    input wire logic irqAllowOp,
    input wire logic irqBlockOp,
    input wire logic loadSystemRegOp,
    input wire logic loadGateValue,
    input wire logic returnFromInterruptOp,
    input wire logic returnFromNmi,
    input wire logic returnFromException,
    input wire logic restoredGate,
    input wire logic lowPowerMode,
    output logic ackPulse,
    output logic [1:0] ackKind,
    output logic [$clog2(NUM_INT+NUM_EXT)-1:0] ackSource,
    output logic [2:0] ackLevel,
    output logic handlerStart,
    output logic irqGateFlag,
    output logic [7:0] inServiceLevels
);
    localparam int NSRC = NUM_INT + NUM_EXT;
    localparam int IW = $clog2(NSRC);

    // -----------------------------------------
    // State
    // -----------------------------------------
    logic [NSRC-1:0] requestPendingFlag;
    logic [NSRC-1:0] requestMaskBit;
    logic [2:0] priorityLevelField [NSRC];
    logic [NUM_EXT-1:0] extD1;
    logic [NUM_EXT-1:0] extD2;
    logic [NUM_EXT-1:0] extLevel;
    logic nmiPend;
    logic trapPend;
    logic illPend;
    logic nmiActive;
    logic [2:0] winCnt;
    logic [2:0] procCnt;
    ipa_pkg::ipa_state_t state;

    // -----------------------------------------
    // External noise filter
    // -----------------------------------------
    // Level must hold two samples before it counts
    wire [NUM_EXT-1:0] extAgree = ~(extD1 ^ extD2);
    wire [NUM_EXT-1:0] next_extLevel = (extAgree & extD2) | (~extAgree & extLevel);
    wire [NUM_EXT-1:0] extEvent = next_extLevel & ~extLevel;
    wire [NSRC-1:0] srcEvent = {extEvent, intReq};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extD1 <= '0;
            extD2 <= '0;
            extLevel <= '0;
        end else begin
            extD1 <= externalIntPin;
            extD2 <= extD1;
            extLevel <= next_extLevel;
        end
    end

    // -----------------------------------------
    // APB decode
    // -----------------------------------------
    wire apbAccess = psel && penable;
    wire apbCommit = apbAccess && pready;
    wire [11:0] srcOff = paddr - ipa_pkg::REG_SRC_BASE;
    wire isAligned = paddr[1:0] == ipa_pkg::WORD_ALIGN;
    wire isStatus = paddr == ipa_pkg::REG_STATUS;
    wire isSrc = isAligned && paddr >= ipa_pkg::REG_SRC_BASE
        && srcOff[11:2] < 10'(NSRC);
    wire [IW-1:0] srcIdx = srcOff[IW+1:2];
    wire isMapped = isStatus || isSrc;
    wire srcWrite = apbCommit && pwrite && isSrc && pstrb[0];
    // Any touch of a control word holds off the maskable acknowledge window
    wire ctrlAccess = psel && isSrc;

    // -----------------------------------------
    // Arbitration
    // -----------------------------------------
    logic bestFound;
    logic [2:0] bestLevel;
    logic [IW-1:0] bestIdx;
    logic isrBlocks;

    always_comb begin
        bestFound = 1'b0;
        bestLevel = ipa_pkg::LEVEL_LOWEST;
        bestIdx = '0;
        isrBlocks = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (requestPendingFlag[i] && !requestMaskBit[i]
                && (!bestFound || priorityLevelField[i] < bestLevel)) begin
                bestFound = 1'b1;
                bestLevel = priorityLevelField[i];
                bestIdx = IW'(i);
            end
        end
        for (int j = 0; j < ipa_pkg::NUM_LEVELS; j++) begin
            if (inServiceLevels[j] && 3'(j) <= bestLevel) begin
                isrBlocks = 1'b1;
            end
        end
    end

    wire nonSample = irqAllowOp || irqBlockOp || loadSystemRegOp;
    wire idleNow = state == ipa_pkg::ST_IDLE;
    wire holdOff = nonSample || ctrlAccess || lowPowerMode;
    // Only a strictly higher level may preempt the one in service
    wire intEligible = bestFound && !isrBlocks
        && !irqGateFlag && !nmiActive;
    wire winOpen = intEligible && !holdOff && idleNow;

    wire nmiFire = nmiPend && !nmiActive && idleNow && !nonSample;
    wire intFire = !nmiFire && winOpen && winCnt == ipa_pkg::WIN_LAST;
    wire trapFire = !nmiFire && !intFire && trapPend && idleNow && !nonSample;
    wire illFire = !nmiFire && !intFire && !trapFire && illPend
        && idleNow && !nonSample;
    wire anyFire = nmiFire || intFire || trapFire || illFire;

    // -----------------------------------------
    // Acknowledge window counter
    // -----------------------------------------
    // Restarts whenever eligibility drops, so a block op or gate
    // set inside the window cancels the acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            winCnt <= ipa_pkg::CNT_ZERO;
        end else if (!winOpen || intFire) begin
            winCnt <= ipa_pkg::CNT_ZERO;
        end else begin
            winCnt <= winCnt + ipa_pkg::CNT_ONE;
        end
    end

    // -----------------------------------------
    // Acknowledge sequencer
    // -----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ipa_pkg::ST_IDLE;
            procCnt <= ipa_pkg::CNT_ZERO;
            handlerStart <= 1'b0;
        end else begin
            handlerStart <= 1'b0;
            case (state)
                ipa_pkg::ST_IDLE: begin
                    procCnt <= ipa_pkg::CNT_ZERO;
                    if (anyFire) begin
                        state <= ipa_pkg::ST_PROC;
                    end
                end
                ipa_pkg::ST_PROC: begin
                    procCnt <= procCnt + ipa_pkg::CNT_ONE;
                    if (procCnt == ipa_pkg::PROC_LAST - ipa_pkg::CNT_ONE) begin
                        handlerStart <= 1'b1;
                        state <= ipa_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= ipa_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackPulse <= 1'b0;
            ackKind <= ipa_pkg::KIND_NMI;
            ackSource <= '0;
            ackLevel <= ipa_pkg::LEVEL_LOWEST;
        end else begin
            ackPulse <= anyFire;
            if (nmiFire) begin
                ackKind <= ipa_pkg::KIND_NMI;
            end else if (intFire) begin
                ackKind <= ipa_pkg::KIND_MASKABLE;
                ackSource <= bestIdx;
                ackLevel <= bestLevel;
            end else if (trapFire) begin
                ackKind <= ipa_pkg::KIND_TRAP;
            end else if (illFire) begin
                ackKind <= ipa_pkg::KIND_ILLEGAL;
            end
        end
    end

    // -----------------------------------------
    // Non-maskable and exception pending
    // -----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmiPend <= 1'b0;
            trapPend <= 1'b0;
            illPend <= 1'b0;
            nmiActive <= 1'b0;
        end else begin
            nmiPend <= nmiReq || (nmiPend && !nmiFire);
            trapPend <= trapReq || (trapPend && !trapFire);
            illPend <= illegalOpcodeException || (illPend && !illFire);
            if (nmiFire) begin
                nmiActive <= 1'b1;
            end else if (returnFromInterruptOp && returnFromNmi) begin
                nmiActive <= 1'b0;
            end
        end
    end

    // -----------------------------------------
    // Gate flag and in-service levels
    // -----------------------------------------
    logic next_irqGateFlag;
    always_comb begin
        if (anyFire || irqBlockOp) begin
            next_irqGateFlag = 1'b1;
        end else if (irqAllowOp) begin
            next_irqGateFlag = 1'b0;
        end else if (loadSystemRegOp) begin
            next_irqGateFlag = loadGateValue;
        end else if (returnFromInterruptOp) begin
            next_irqGateFlag = restoredGate;
        end else begin
            next_irqGateFlag = irqGateFlag;
        end
    end

    // Maskable return drops the highest-priority (lowest) set bit
    wire isrRet = returnFromInterruptOp && !returnFromNmi && !returnFromException;
    wire [7:0] isrCleared = isrRet
        ? (inServiceLevels & (inServiceLevels - ipa_pkg::ISR_ONE))
        : inServiceLevels;
    wire [7:0] isrSet = intFire ? (ipa_pkg::ISR_ONE << bestLevel) : '0;
    wire [7:0] next_inServiceLevels = isrCleared | isrSet;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqGateFlag <= ipa_pkg::GATE_RESET;
            inServiceLevels <= '0;
        end else begin
            irqGateFlag <= next_irqGateFlag;
            inServiceLevels <= next_inServiceLevels;
        end
    end

    // -----------------------------------------
    // Request control words
    // -----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : gSrc
            wire hit = srcWrite && srcIdx == IW'(g);
            wire ackClr = intFire && bestIdx == IW'(g);
            wire swClr = hit && !pwdata[ipa_pkg::FLD_PEND];
            wire swSet = hit && pwdata[ipa_pkg::FLD_PEND];
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    requestPendingFlag[g] <= 1'b0;
                    requestMaskBit[g] <= ipa_pkg::RST_MASK;
                    priorityLevelField[g] <= ipa_pkg::LEVEL_LOWEST;
                end else begin
                    // New event beats a clear in the same cycle
                    requestPendingFlag[g] <= srcEvent[g] || swSet
                        || (requestPendingFlag[g] && !ackClr && !swClr);
                    if (hit) begin
                        requestMaskBit[g] <= pwdata[ipa_pkg::FLD_MASK];
                        priorityLevelField[g] <= pwdata[ipa_pkg::FLD_PRIO_LSB +: 3];
                    end
                end
            end
        end
    endgenerate

    // -----------------------------------------
    // APB read path
    // -----------------------------------------
    wire [31:0] srcWord = 32'({requestPendingFlag[srcIdx], requestMaskBit[srcIdx],
        3'h0, priorityLevelField[srcIdx]});
    wire [31:0] statWord = 32'({!idleNow, nmiActive, irqGateFlag, inServiceLevels});
    wire [31:0] readMux = isStatus ? statWord : (isSrc ? srcWord : '0);

    // One wait state: answer registered on the first access cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= apbAccess && !pready;
            if (apbAccess && !pready) begin
                prdata <= pwrite ? '0 : readMux;
                pslverr <= !isMapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule

// ### tb/ipa_irq_ctrl_properties.sv
`timescale 1ns/100ps
module ipa_irq_ctrl_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic irqAllowOp,
    input wire logic irqBlockOp,
    input wire logic loadSystemRegOp,
    input wire logic returnFromInterruptOp,
    input wire logic returnFromNmi,
    input wire logic returnFromException,
    input wire logic lowPowerMode,
    input wire logic ackPulse,
    input wire logic [1:0] ackKind,
    input wire logic [2:0] ackLevel,
    input wire logic handlerStart,
    input wire logic irqGateFlag,
    input wire logic [7:0] inServiceLevels
);
    // ------------
    // Checks
    // ------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire mAck = ackPulse && ackKind == ipa_pkg::KIND_MASKABLE;
    wire plainRet = returnFromInterruptOp && !returnFromNmi && !returnFromException;
    a_quiet_after_reset: assert property ($fell(rst) |-> !ackPulse)
        else $error("ack at reset release");
    a_ack_sets_gate: assert property (ackPulse |-> irqGateFlag)
        else $error("gate not set by ack");
    a_gate_was_clear: assert property (mAck |-> !$past(irqGateFlag))
        else $error("maskable ack with gate set");
    a_ack_outranks: assert property (mAck |-> ($past(inServiceLevels) & ~(8'hfe << ackLevel)) == 8'h00)
        else $error("ack not above in-service level");
    a_level_in_service: assert property (mAck |-> inServiceLevels[ackLevel])
        else $error("in-service bit missing");
    a_start_delay: assert property (ackPulse |-> ##3 handlerStart)
        else $error("handler start late");
    a_nosample_hold: assert property ((irqAllowOp || irqBlockOp || loadSystemRegOp) |=> !ackPulse)
        else $error("ack after non-sampling op");
    a_allow_window: assert property (irqAllowOp |=> (!mAck) [*7])
        else $error("ack inside allow window");
    a_low_power: assert property (lowPowerMode |=> !mAck)
        else $error("ack in low power");
    a_ret_pops: assert property (plainRet |=> ackPulse
        || inServiceLevels == ($past(inServiceLevels) & ($past(inServiceLevels) - 8'h01)))
        else $error("return did not pop level");
    c_nested: cover property (mAck && inServiceLevels[3] && ackLevel == 3'h1);
    c_nmi: cover property (ackPulse && ackKind == ipa_pkg::KIND_NMI);
    c_start: cover property (handlerStart);
endmodule

bind ipa_irq_ctrl ipa_irq_ctrl_chk chk_u (.clk, .rst, .irqAllowOp, .irqBlockOp, .loadSystemRegOp,
    .returnFromInterruptOp, .returnFromNmi, .returnFromException, .lowPowerMode, .ackPulse,
    .ackKind, .ackLevel, .handlerStart, .irqGateFlag, .inServiceLevels);

// ### tb/ipa_cpu_model.sv
`timescale 1ns/100ps
module ipa_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic ackPulse,
    input wire logic [1:0] ackKind,
    input wire logic irqGateFlag,
    input wire logic doReturn,
    output logic returnFromInterruptOp,
    output logic returnFromNmi,
    output logic returnFromException,
    output logic restoredGate
);
    // ------------
    // Handler stack
    // ------------
    // Saved context per nesting level, restored on return
    logic [1:0] kindStack [8];
    logic gateStack [8];
    logic prevGate;
    logic [2:0] depth;
    wire [2:0] top = depth - 3'h1;
    // Qualifiers gated by the return so unused slots never leak
    assign returnFromInterruptOp = doReturn;
    assign returnFromNmi = doReturn && kindStack[top] == ipa_pkg::KIND_NMI;
    assign returnFromException = doReturn && kindStack[top][1];
    assign restoredGate = doReturn && gateStack[top];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            depth <= 3'h0;
            prevGate <= 1'b1;
        end else begin
            prevGate <= irqGateFlag;
            if (ackPulse) begin
                kindStack[depth] <= ackKind;
                gateStack[depth] <= prevGate;
                depth <= depth + 3'h1;
            end else if (doReturn) begin
                depth <= top;
            end
        end
    end
endmodule

// ### tb/ipa_irq_ctrl_tb.sv
`timescale 1ns/100ps
module ipa_irq_ctrl_tb;
    localparam logic [6:0] OP_ALLOW = 7'h01, OP_BLOCK = 7'h02, OP_LOAD = 7'h04, OP_RET = 7'h40;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, lowPowerMode, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] intReq, externalIntPin;
    logic [6:0] ev;
    logic retOp, retNmi, retExc, resGate, ackPulse, handlerStart, irqGateFlag;
    logic [1:0] ackKind;
    logic [2:0] ackSource, ackLevel;
    logic [7:0] inServiceLevels;
    int fail_count = 0, n_compared = 0, n, nExt;
    ipa_irq_ctrl #(.NUM_INT(4), .NUM_EXT(4)) dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .pready, .prdata, .pslverr, .intReq, .externalIntPin, .nmiReq(ev[3]), .trapReq(ev[4]),
        .illegalOpcodeException(ev[5]), .irqAllowOp(ev[0]), .irqBlockOp(ev[1]), .loadSystemRegOp(ev[2]),
        .loadGateValue(1'b0), .returnFromInterruptOp(retOp), .returnFromNmi(retNmi),
        .returnFromException(retExc), .restoredGate(resGate), .lowPowerMode, .ackPulse, .ackKind,
        .ackSource, .ackLevel, .handlerStart, .irqGateFlag, .inServiceLevels);
    ipa_cpu_model cpu_u (.clk, .rst, .ackPulse, .ackKind, .irqGateFlag, .doReturn(ev[6]),
        .returnFromInterruptOp(retOp), .returnFromNmi(retNmi), .returnFromException(retExc),
        .restoredGate(resGate));
    // ------------
    // Helpers
    // ------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [11:0] cw(input int i);
        return ipa_pkg::REG_SRC_BASE + 12'(4 * i);
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One-cycle op or source pulse; returns on the edge that ends it
    task automatic fire(input logic [6:0] e, input logic [3:0] irq);
        @(posedge clk);
        ev <= e;
        intReq <= irq;
        @(posedge clk);
        ev <= 7'h00;
        intReq <= 4'h0;
    endtask
    // n = cycles after the last driven edge until ack (or handler start)
    task automatic waitT(input logic start, input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((start ? handlerStart : ackPulse) !== 1'b1 && n < lim);
    endtask
    // ------------
    // Scenarios
    // ------------
    task automatic resetVals;
        apb(1'b1, ipa_pkg::REG_STATUS, 32'h0);
        apb(1'b0, ipa_pkg::REG_STATUS, 32'h0);
        check(rd, 32'h100);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, cw(i), 32'h0);
            check(rd, 32'h47);
        end
        apb(1'b0, 12'h800, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 12'h042, 32'h0);
        check(err, 1'b1);
    endtask
    task automatic firstAck;
        // Control word edited here while the gate is still set from reset
        apb(1'b1, cw(0), 32'h03);
        fire(7'h00, 4'h1);
        waitT(1'b0, 20);
        check(ackPulse, 1'b0);
        fire(OP_ALLOW, 4'h0);
        waitT(1'b0, 20);
        check(32'(n), 32'd8);
        check(ackKind, ipa_pkg::KIND_MASKABLE);
        check(ackLevel, 3'h3);
        check(irqGateFlag, 1'b1);
        check(inServiceLevels, 8'h08);
        waitT(1'b1, 20);
        check(32'(n), 32'd3);
        apb(1'b0, cw(0), 32'h0);
        check(rd, 32'h03);
    endtask
    task automatic nesting;
        apb(1'b1, cw(1), 32'h03);
        apb(1'b1, cw(2), 32'h01);
        fire(7'h00, 4'h6);
        fire(OP_ALLOW, 4'h0);
        waitT(1'b0, 20);
        check(ackSource, 3'h2);
        check(inServiceLevels, 8'h0a);
        fire(OP_RET, 4'h0);
        waitT(1'b0, 20);
        check(ackPulse, 1'b0);
        check(inServiceLevels, 8'h08);
        fire(OP_RET, 4'h0);
        waitT(1'b0, 20);
        check(ackSource, 3'h1);
    endtask
    task automatic blockWindow;
        apb(1'b1, cw(0), 32'h02);
        fire(7'h00, 4'h1);
        fire(OP_ALLOW, 4'h0);
        repeat (3) @(posedge clk);
        fire(OP_BLOCK, 4'h0);
        waitT(1'b0, 20);
        check(ackPulse, 1'b0);
        @(posedge clk);
        lowPowerMode <= 1'b1;
        fire(OP_LOAD, 4'h0);
        waitT(1'b0, 20);
        check(ackPulse, 1'b0);
        check(irqGateFlag, 1'b0);
        @(posedge clk);
        lowPowerMode <= 1'b0;
        waitT(1'b0, 20);
        check(ackSource, 3'h0);
        repeat (2) fire(OP_RET, 4'h0);
        @(negedge clk);
        check(inServiceLevels, 8'h00);
    endtask
    task automatic exceptOrder;
        apb(1'b1, cw(3), 32'h00);
        fire(7'h38, 4'h8);
        waitT(1'b0, 20);
        check(ackKind, ipa_pkg::KIND_NMI);
        waitT(1'b0, 20);
        check(ackKind, ipa_pkg::KIND_TRAP);
        waitT(1'b0, 20);
        check(ackKind, ipa_pkg::KIND_ILLEGAL);
        fire(OP_ALLOW, 4'h0);
        waitT(1'b0, 20);
        check(ackPulse, 1'b0);
        repeat (3) fire(OP_RET, 4'h0);
        waitT(1'b0, 20);
        check(ackSource, 3'h3);
        fire(OP_RET, 4'h0);
    endtask
    task automatic latency;
        apb(1'b1, cw(4), 32'h00);
        @(posedge clk);
        externalIntPin <= 4'h1;
        @(posedge clk);
        waitT(1'b1, 40);
        nExt = n;
        check(nExt >= 13 && nExt <= 20, 1'b1);
        fire(OP_RET, 4'h0);
        externalIntPin <= 4'h0;
        fire(7'h00, 4'h1);
        waitT(1'b1, 40);
        check(n >= 11 && n <= 18, 1'b1);
        check(32'(nExt - n), 32'd2);
        fire(OP_RET, 4'h0);
        fire(7'h00, 4'h1);
        repeat (3) @(posedge clk);
        fire(OP_BLOCK, 4'h0);
        waitT(1'b0, 20);
        check(ackPulse, 1'b0);
        apb(1'b1, cw(1), 32'h02);
        fire(OP_ALLOW, 4'h2);
        waitT(1'b0, 20);
        check(ackSource, 3'h0);
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, lowPowerMode} = 4'h0;
        {paddr, pwdata, intReq, externalIntPin, ev} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        resetVals();
        firstAck();
        nesting();
        blockWindow();
        exceptOrder();
        latency();
        summarize();
    end
    initial begin
        #50000;
        fail_count++;
        summarize();
    end
endmodule
